// *** verilog/ptio_ctrl.v ***
// What this block does
// - eight command codes; combined codes do both
// - stop latched, executed after next character once two are read
// - inhibit drops request, service still recorded
// - every receiver command clears timing error
// - allow acts at once, reraises pending request
// - read starts only when reader ready
// - each read reads at least two characters
// - data-in acknowledged only for fresh valid character
// - msb on line 8, lsb on line 15
// - data-out acknowledged unless busy or not ready
// - address-in drives requester address, no acknowledge
// - status-in drives status byte, no acknowledge
// - receiver not ready status reads 0x40
// - punch not ready status reads 0x40
// - overrun status reads 0x04
// - servicing instruction clears interrupt request
// - data-in clears receiver service-required state
// - transmitter even address, receiver next odd
// - receiver requests interrupt on each character
// - transmitter requests interrupt after each punch
// - status-in clears request and status indicator
`timescale 1ns/10ps
`default_nettype none
`include "ptio_defs.vh"
module ptio_ctrl #(
   parameter [7:0] STATION = `PTIO_STATION_DEF,
   parameter PUNCH_CYCLES = `PTIO_PUNCH_CYC
) (
   input wire clock,
   input wire rst_b,
   input wire [7:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire command_out_instr,
   input wire data_in_instr,
   input wire data_out_instr,
   input wire address_in_instr,
   input wire status_in_instr,
   output reg [0:7] bus_rdata_ff,
   output reg ack_ff,
   output reg rx_irq_ff,
   output reg tx_irq_ff,
   input wire rdr_run,
   input wire rdr_spool_on,
   input wire rdr_rewind_off,
   input wire rdr_power_on,
   input wire rdr_char_strobe,
   input wire [7:0] rdr_char,
   output reg rdr_drive_ff,
   input wire pun_power_on,
   input wire pun_tape_in,
   input wire pun_low_tape,
   output reg [7:0] pun_data_ff,
   output reg pun_start_ff
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   function is_code;
      input [7:0] c;
      begin
         is_code = (c == `PTIO_CMD_READ) || (c == `PTIO_CMD_STOP) ||
            (c == `PTIO_CMD_INH) || (c == `PTIO_CMD_RD_INH) ||
            (c == `PTIO_CMD_ST_INH) || (c == `PTIO_CMD_ALW) ||
            (c == `PTIO_CMD_RD_ALW) || (c == `PTIO_CMD_ST_ALW);
      end
   endfunction

   // bit0 of the byte lands on line 15, so a reversed vector index keeps msb on line 8
   function [0:7] to_lines;
      input [7:0] b;
      begin
         to_lines = b;
      end
   endfunction

   wire [7:0] tx_addr = {STATION[7:1], 1'b0};
   wire [7:0] rx_addr = {STATION[7:1], 1'b1};
   wire sel_tx = (bus_addr == tx_addr);
   wire sel_rx = (bus_addr == rx_addr);

   wire cmd_ok = command_out_instr && is_code(bus_wdata);
   wire rx_cmd = cmd_ok && sel_rx;
   wire tx_cmd = cmd_ok && sel_tx && ((bus_wdata == `PTIO_CMD_INH) ||
      (bus_wdata == `PTIO_CMD_ALW));
   wire c_read = bus_wdata[0];
   wire c_stop = bus_wdata[1];
   wire c_inh = bus_wdata[2] || (bus_wdata == `PTIO_CMD_ST_INH);
   wire c_alw = bus_wdata[3];

   wire rdr_ready = rdr_run && rdr_spool_on && rdr_rewind_off && rdr_power_on;
   wire pun_dnr = !pun_power_on || !pun_tape_in || pun_low_tape;

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg rx_allow_ff, tx_allow_ff;
   reg rx_svc_ff, tx_svc_ff;
   reg rx_new_ff, terr_ff;
   reg stop_pend_ff;
   reg [1:0] char_cnt_ff;
   reg [7:0] rx_buf_ff;
   reg rx_dnr_int_ff;
   reg tx_dnr_ff;
   wire pun_busy, pun_done;

   ptio_punch_timer #(
      .CYCLES(PUNCH_CYCLES)
   ) u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .start(pun_start_ff),
      .busy_ff(pun_busy),
      .done_ff(pun_done)
   );

   wire di = data_in_instr && sel_rx;
   wire do_ = data_out_instr && sel_tx;
   wire si_rx = status_in_instr && sel_rx;
   wire si_tx = status_in_instr && sel_tx;
   wire ai = address_in_instr;
   wire di_ok = di && rx_new_ff && !terr_ff && rdr_ready;
   wire do_free = !pun_busy && !pun_start_ff;
   wire do_ok = do_ && do_free && !pun_dnr;
   wire do_take = do_ && do_free;
   wire ai_rx = ai && rx_irq_ff;
   wire ai_tx = ai && tx_irq_ff && !rx_irq_ff;
   wire rd_start = rx_cmd && c_read;

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   always @(posedge clock) begin
      if (!rst_b) begin
         rx_allow_ff <= 1'b0;
         rx_svc_ff <= 1'b0;
         rx_new_ff <= 1'b0;
         terr_ff <= 1'b0;
         stop_pend_ff <= 1'b0;
         char_cnt_ff <= 2'h0;
         rx_buf_ff <= 8'h00;
         rdr_drive_ff <= 1'b0;
         rx_dnr_int_ff <= 1'b0;
      end else begin
         if (rx_cmd && c_inh) rx_allow_ff <= 1'b0;
         if (rx_cmd && c_alw) rx_allow_ff <= 1'b1;
         if (rx_cmd) begin
            if (rd_start && rdr_ready) begin
               rdr_drive_ff <= 1'b1;
               char_cnt_ff <= 2'h0;
               stop_pend_ff <= 1'b0;
            end
            if (c_stop) stop_pend_ff <= 1'b1;
         end
         if (rd_start && !rdr_ready) rx_dnr_int_ff <= 1'b1;
         else if (si_rx || ai_rx) rx_dnr_int_ff <= 1'b0;
         // clears first, so a character in the same cycle wins
         if (rx_cmd || si_rx) terr_ff <= 1'b0;
         if (di) rx_svc_ff <= 1'b0;
         if (di_ok) rx_new_ff <= 1'b0;
         if (rdr_char_strobe && rdr_drive_ff) begin
            rx_buf_ff <= rdr_char;
            rx_svc_ff <= 1'b1;
            rx_new_ff <= 1'b1;
            if (rx_new_ff && !di_ok) terr_ff <= 1'b1;
            if (char_cnt_ff != `PTIO_MIN_CHARS) char_cnt_ff <= char_cnt_ff + 2'h1;
            if ((stop_pend_ff || (rx_cmd && c_stop)) &&
                  (char_cnt_ff + 2'h1 >= `PTIO_MIN_CHARS)) begin
               rdr_drive_ff <= 1'b0;
               stop_pend_ff <= 1'b0;
            end
         end else if (stop_pend_ff && !rdr_drive_ff) begin
            stop_pend_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   always @(posedge clock) begin
      if (!rst_b) begin
         tx_allow_ff <= 1'b0;
         tx_svc_ff <= 1'b0;
         tx_dnr_ff <= 1'b0;
         pun_data_ff <= 8'h00;
         pun_start_ff <= 1'b0;
      end else begin
         pun_start_ff <= 1'b0;
         if (tx_cmd && c_inh) tx_allow_ff <= 1'b0;
         if (tx_cmd && c_alw) tx_allow_ff <= 1'b1;
         if (do_take) begin
            // byte is punched even when not acknowledged
            pun_data_ff <= bus_wdata;
            pun_start_ff <= 1'b1;
         end
         if (do_ok) tx_svc_ff <= 1'b0;
         if (si_tx) tx_dnr_ff <= 1'b0;
         if (pun_done) tx_svc_ff <= 1'b1;
         if (do_ && pun_dnr) tx_dnr_ff <= 1'b1;
      end
   end

   // ----------------------------------------
   // interrupt requests
   // ----------------------------------------
   // request lines are recomputed from held service state, so allow reraises at once
   reg rx_req_clr_ff, tx_req_clr_ff;
   always @(posedge clock) begin
      if (!rst_b) begin
         rx_req_clr_ff <= 1'b0;
         tx_req_clr_ff <= 1'b0;
         rx_irq_ff <= 1'b0;
         tx_irq_ff <= 1'b0;
      end else begin
         if (rdr_char_strobe && rdr_drive_ff) rx_req_clr_ff <= 1'b0;
         else if (ai_rx || di || si_rx) rx_req_clr_ff <= 1'b1;
         if (pun_done) tx_req_clr_ff <= 1'b0;
         else if (ai_tx || do_ok || si_tx) tx_req_clr_ff <= 1'b1;
         rx_irq_ff <= !(rx_cmd && c_inh) && (rx_allow_ff || (rx_cmd && c_alw)) &&
            ((rx_svc_ff && !rx_req_clr_ff && !di && !si_rx && !ai_rx) ||
            (rdr_char_strobe && rdr_drive_ff) || (rd_start && !rdr_ready) ||
            (rx_dnr_int_ff && !si_rx && !ai_rx));
         tx_irq_ff <= !(tx_cmd && c_inh) && (tx_allow_ff || (tx_cmd && c_alw)) &&
            ((tx_svc_ff && !tx_req_clr_ff && !ai_tx && !do_ok && !si_tx) ||
            pun_done || (do_ && pun_dnr));
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   reg [7:0] rx_stat, tx_stat;
   always @* begin
      rx_stat = `PTIO_STAT_NONE;
      if (!rdr_ready || rx_dnr_int_ff) rx_stat = `PTIO_STAT_DNR;
      else if (terr_ff) rx_stat = `PTIO_STAT_TERR;
      tx_stat = (pun_dnr || tx_dnr_ff) ? `PTIO_STAT_DNR : `PTIO_STAT_NONE;
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         bus_rdata_ff <= 8'h00;
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (rx_cmd || tx_cmd) || di_ok || do_ok;
         bus_rdata_ff <= 8'h00;
         if (di) bus_rdata_ff <= to_lines(rx_buf_ff);
         else if (si_rx) bus_rdata_ff <= to_lines(rx_stat);
         else if (si_tx) bus_rdata_ff <= to_lines(tx_stat);
         else if (ai_rx) bus_rdata_ff <= to_lines(rx_addr);
         else if (ai_tx) bus_rdata_ff <= to_lines(tx_addr);
      end
   end
endmodule
`default_nettype wire

// *** verilog/ptio_defs.vh ***
`ifndef PTIO_DEFS_VH
`define PTIO_DEFS_VH
// command codes in the low command byte
`define PTIO_CMD_READ 8'h01
`define PTIO_CMD_STOP 8'h02
`define PTIO_CMD_INH 8'h04
`define PTIO_CMD_RD_INH 8'h05
`define PTIO_CMD_ST_INH 8'h06
`define PTIO_CMD_ALW 8'h08
`define PTIO_CMD_RD_ALW 8'h09
`define PTIO_CMD_ST_ALW 8'h0A
// status bytes
`define PTIO_STAT_NONE 8'h00
`define PTIO_STAT_TERR 8'h04
`define PTIO_STAT_DNR 8'h40
// default station address of the transmitter (even, nonzero)
`define PTIO_STATION_DEF 8'h10
// minimum characters per read command
`define PTIO_MIN_CHARS 2'h2
// punch cycle length: 60 characters per second at 100 MHz
`define PTIO_PUNCH_US 16667
`define PTIO_CLK_MHZ 100
`define PTIO_PUNCH_CYC (`PTIO_PUNCH_US * `PTIO_CLK_MHZ)
`endif

// *** verilog/ptio_punch_timer.v ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// punch cycle timer
// ----------------------------------------
module ptio_punch_timer #(
   parameter CYCLES = 1666700
) (
   input wire clock,
   input wire rst_b,
   input wire start,
   output reg busy_ff,
   output reg done_ff
);
   reg [31:0] cnt_ff;
   always @(posedge clock) begin
      if (!rst_b) begin
         cnt_ff <= 32'h0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff <= 32'h0;
         end else if (busy_ff) begin
            if (cnt_ff >= CYCLES - 1) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/ptio_ctrl_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module ptio_chk #(
   parameter [7:0] STATION = 8'h10
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic command_out_instr,
   input wire logic data_in_instr,
   input wire logic data_out_instr,
   input wire logic address_in_instr,
   input wire logic status_in_instr,
   input wire logic [0:7] bus_rdata_ff,
   input wire logic ack_ff,
   input wire logic rx_irq_ff,
   input wire logic tx_irq_ff,
   input wire logic rdr_run,
   input wire logic rdr_spool_on,
   input wire logic rdr_rewind_off,
   input wire logic rdr_power_on,
   input wire logic rdr_drive_ff,
   input wire logic pun_power_on,
   input wire logic pun_tape_in,
   input wire logic pun_low_tape
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire rx = bus_addr == (STATION | 8'h01);
   wire tx = bus_addr == (STATION & 8'hFE);
   wire rdy = rdr_run && rdr_spool_on && rdr_rewind_off;
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !ack_ff && !rx_irq_ff
      && !tx_irq_ff && !rdr_drive_ff) else $error("outputs active after reset");
   a_cmd_ack: assert property (command_out_instr && rx && bus_wdata inside {8'h01, 8'h02,
      8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A} |=> ack_ff) else $error("command not acked");
   a_rx_inhibit: assert property (command_out_instr && rx && bus_wdata inside {8'h04, 8'h05,
      8'h06} |=> !rx_irq_ff) else $error("receiver request not dropped");
   a_tx_inhibit: assert property (command_out_instr && tx && bus_wdata == 8'h04
      |=> !tx_irq_ff [*2]) else $error("transmitter request not dropped");
   a_read_start: assert property (command_out_instr && rx && bus_wdata inside {8'h01, 8'h05,
      8'h09} && rdy && rdr_power_on |=> ##[0:2] rdr_drive_ff) else $error("reader not started");
   a_din_notready: assert property (data_in_instr && rx && !rdy |=> !ack_ff)
      else $error("data-in acked with reader not ready");
   a_dout_dnr: assert property (data_out_instr && tx && !(pun_power_on && pun_tape_in
      && !pun_low_tape) |=> !ack_ff) else $error("data-out acked with punch not ready");
   a_ack_cause: assert property (ack_ff |-> $past(command_out_instr || data_in_instr
      || data_out_instr)) else $error("acknowledge without cause");
   a_query_noack: assert property (address_in_instr || status_in_instr |=> !ack_ff)
      else $error("query acked");
   a_addr_in: assert property (address_in_instr && rx_irq_ff |=> bus_rdata_ff ==
      (STATION | 8'h01)) else $error("wrong requester address");
   a_tx_dnr: assert property (status_in_instr && tx && !pun_power_on |=>
      bus_rdata_ff == 8'h40) else $error("punch status wrong");
   a_rx_dnr: assert property (status_in_instr && rx && !rdr_power_on |=>
      bus_rdata_ff[1]) else $error("reader status wrong");
endmodule
bind ptio_ctrl ptio_chk #(.STATION(STATION)) u_ptio_chk (.*);
`default_nettype wire

// *** verif/ptio_tape_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// reader model: one character every GAP+1 cycles while driven
// ----------------------------------------
module ptio_tape_model #(
   parameter GAP = 60
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic rdr_drive_ff,
   output logic rdr_char_strobe = 1'b0,
   output logic [7:0] rdr_char = 8'hA5
);
   logic [7:0] cnt_ff = 8'h00;
   logic [7:0] seq_ff = 8'h31;
   always @(posedge clock) begin
      rdr_char_strobe <= 1'b0;
      // data lines are only valid with the strobe, so keep them moving
      rdr_char <= ~rdr_char;
      if (!rst_b || !rdr_drive_ff) begin
         cnt_ff <= 8'h00;
      end else if (cnt_ff == GAP) begin
         cnt_ff <= 8'h00;
         rdr_char_strobe <= 1'b1;
         rdr_char <= seq_ff;
         seq_ff <= seq_ff + 8'h13;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule
`default_nettype wire

// *** verif/ptio_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module ptio_ctrl_tb_top;
   localparam [7:0] TX = 8'h10;
   localparam [7:0] RX = 8'h11;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic [4:0] strb = 5'h00;
   logic [3:0] rdy = 4'hF;
   logic [2:0] pun = 3'h3;
   wire [0:7] bus_rdata_ff;
   wire ack_ff, rx_irq_ff, tx_irq_ff, rdr_drive_ff, rdr_char_strobe, pun_start_ff;
   wire [7:0] rdr_char, pun_data_ff;
   wire [2:0] mon = {rdr_drive_ff, tx_irq_ff, rx_irq_ff};
   logic [9:0] exp_q[$];
   logic [9:0] e;
   logic pend = 1'b0;
   logic [7:0] last_char = 8'h00;
   logic [7:0] nchar = 8'h00;
   logic [7:0] n0;
   logic [7:0] npun = 8'h00;
   logic [31:0] seed = 32'h25;
   logic [7:0] codes[8] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A};
   int num_errors = 0;
   int compares = 0;
   initial begin
      forever #5 clock = ~clock;
   end
   ptio_ctrl #(.STATION(TX), .PUNCH_CYCLES(20)) u_ptio_ctrl (.*, .command_out_instr(strb[0]),
      .data_in_instr(strb[1]), .data_out_instr(strb[2]), .address_in_instr(strb[3]),
      .status_in_instr(strb[4]), .rdr_run(rdy[0]), .rdr_spool_on(rdy[1]),
      .rdr_rewind_off(rdy[2]), .rdr_power_on(rdy[3]), .pun_power_on(pun[0]),
      .pun_tape_in(pun[1]), .pun_low_tape(pun[2]));
   ptio_tape_model u_ptio_tape_model (.*);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic summarize;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      compares++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // entry: {check data, ack, data}
   task automatic req(input int k, input logic [7:0] a, input logic [7:0] d, input logic [9:0] x);
      @(posedge clock);
      strb <= 5'h01 << k;
      bus_addr <= a;
      bus_wdata <= d;
      exp_q.push_back(x);
      @(posedge clock);
      strb <= 5'h00;
   endtask
   task automatic wt(input int s, input logic v);
      for (int n = 0; n < 3000; n++) begin
         @(posedge clock);
         if (mon[s] === v) return;
      end
      num_errors++;
      summarize();
   endtask
   task automatic wc(input logic [7:0] k);
      n0 = nchar + k;
      for (int n = 0; n < 3000; n++) begin
         @(posedge clock);
         if (nchar == n0) return;
      end
      num_errors++;
      summarize();
   endtask
   always @(posedge clock) begin
      pend <= |strb;
      if (rdr_char_strobe) begin
         last_char <= rdr_char;
         nchar <= nchar + 8'h01;
      end
      // every accepted punch byte, acknowledged or not, must start one punch cycle
      if (pun_start_ff) npun <= npun + 8'h01;
      if (pend) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF;
         chk({7'h00, ack_ff}, {7'h00, e[8]});
         if (e[9]) chk(bus_rdata_ff, e[7:0]);
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      chk({4'h0, rx_irq_ff, tx_irq_ff, rdr_drive_ff, ack_ff}, 8'h00);
      rdy <= 4'h6;
      foreach (codes[i]) req(0, RX, codes[i], 10'h100);
      req(0, RX, 8'h03, 10'h000);
      req(0, TX, 8'h01, 10'h000);
      req(1, RX, 8'h00, 10'h000);
      req(4, RX, 8'h00, 10'h240);
      $display("commands done");
      rdy <= 4'hF;
      req(0, RX, 8'h09, 10'h100);
      wt(0, 1'b1);
      req(3, RX, 8'h00, {2'h2, RX});
      @(posedge clock);
      wt(0, 1'b0);
      req(1, RX, 8'h00, {2'h3, last_char});
      req(1, RX, 8'h00, 10'h000);
      $display("read done");
      req(0, RX, 8'h04, 10'h100);
      wc(8'h02);
      chk({7'h00, rx_irq_ff}, 8'h00);
      req(1, RX, 8'h00, 10'h000);
      req(4, RX, 8'h00, 10'h204);
      wc(8'h01);
      req(0, RX, 8'h0A, 10'h100);
      wt(0, 1'b1);
      req(1, RX, 8'h00, {2'h3, last_char});
      wt(2, 1'b0);
      req(1, RX, 8'h00, {2'h3, last_char});
      n0 = nchar;
      req(0, RX, 8'h01, 10'h100);
      req(0, RX, 8'h02, 10'h100);
      wt(2, 1'b0);
      chk(nchar - n0, 8'h02);
      $display("overrun and stop done");
      seed = xs(seed);
      req(0, TX, 8'h08, 10'h100);
      req(2, TX, seed[7:0], 10'h100);
      req(2, TX, 8'h5A, 10'h000);
      wt(1, 1'b1);
      chk(pun_data_ff, seed[7:0]);
      req(4, TX, 8'h00, 10'h200);
      wt(1, 1'b0);
      pun <= 3'h2;
      req(2, TX, 8'h33, 10'h000);
      req(4, TX, 8'h00, 10'h240);
      pun <= 3'h3;
      req(0, TX, 8'h04, 10'h100);
      wt(1, 1'b0);
      repeat (4) @(posedge clock);
      chk(npun, 8'h02);
      $display("transmitter done");
      summarize();
   end
endmodule
`default_nettype wire
